// >>> hdl/pis_pkg.sv
/*
  Constants for the priority interrupt system: level states, command
  codes, register offsets and field positions.
  Assumes a 32-bit APB register bus with 12-bit byte addresses.
*/
package pis_pkg;

  // Default shape: groups of fixed-priority levels
  localparam int GROUPS_DEF  = 4;
  localparam int LEVELS_DEF  = 16;
  localparam int PF_GROUP    = 0;             // Power-fail group, always first
  localparam int PF_LEVELS   = 2;             // Two top levels reserved for it
  // Groups that own an inhibit; the power-fail group has none
  localparam logic [GROUPS_DEF-1:0] INHIBIT_MASK_DEF = 4'hE;

  // Level state, Gray order along disarmed-armed-waiting-active
  typedef enum logic [1:0] {
    DISARMED = 2'h0,
    ARMED    = 2'h1,
    WAITING  = 2'h3,
    ACTIVE   = 2'h2
  } lvl_state_t;

  // Command codes in the command register
  typedef enum logic [2:0] {
    OP_NONE    = 3'h0,
    OP_ARM     = 3'h1,
    OP_DISARM  = 3'h2,
    OP_ENABLE  = 3'h3,
    OP_DISABLE = 3'h4,
    OP_TRIGGER = 3'h5,
    OP_GRP_EN  = 3'h6,
    OP_GRP_DIS = 3'h7
  } cmd_op_t;

  // APB map, byte addresses
  localparam int          APB_AW      = 12;
  localparam logic [11:0] INHIBIT_OFS = 12'h000;
  localparam logic [11:0] ORDER_OFS   = 12'h004;
  localparam logic [11:0] STATUS_OFS  = 12'h008;
  localparam logic [11:0] CMD_OFS     = 12'h00C;
  localparam logic [11:0] LEVEL_BASE  = 12'h040;
  localparam logic [11:0] LVL_STRIDE  = 12'h008;
  localparam logic [11:0] ENABLE_OFS  = 12'h004;

  // Field positions
  localparam int CMD_IDX_LSB  = 0;
  localparam int CMD_OP_LSB   = 8;
  localparam int STAT_REQ_BIT = 31;
  localparam int STAT_ACT_BIT = 30;
  localparam int ST_BITS      = 2;

endpackage : pis_pkg

// >>> hdl/priority_interrupt_system.sv
/*
  Priority interrupt system: per-level state machines, parallel
  priority network over configurable group order, processor request
  and acknowledge, APB register slave for control and save/restore.
  Assumes one clock pclk, async active-low presetn, level_signal pins
  asynchronous, cpu_ack from logic on pclk.
*/
`timescale 1ns/1ps
module priority_interrupt_system
  import pis_pkg::*;
#(
  parameter int                    GROUPS       = GROUPS_DEF,
  parameter int                    LEVELS       = LEVELS_DEF,
  parameter logic [GROUPS_DEF-1:0] INHIBIT_MASK = INHIBIT_MASK_DEF
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic [APB_AW-1:0]         paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [GROUPS*LEVELS-1:0]  level_signal,
  output logic                           req_valid,
  output logic [$clog2(GROUPS*LEVELS)-1:0] req_level,
  input  wire logic                      cpu_ack,
  output logic                           active_any
);

  localparam int N  = GROUPS * LEVELS;
  localparam int LW = $clog2(LEVELS);
  localparam int GW = $clog2(GROUPS);
  localparam int IW = LW + GW;

  // Shapes the logic cannot serve
  if (LEVELS > 16 || LEVELS < 2 || (1 << LW) != LEVELS) begin : g_bad_lv
    $error("LEVELS must be a power of two from 2 to 16");
  end
  if (GROUPS < 2 || GROUPS > GROUPS_DEF || (1 << GW) != GROUPS) begin : g_bad_gr
    $error("GROUPS must be a power of two from 2 to 4");
  end

  // Whole block state
  typedef struct packed {
    lvl_state_t [N-1:0]          st;        // Per-level condition
    logic [N-1:0]                en;        // Per-level enable
    logic [N-1:0]                sync1;     // Pin synchroniser, stage one
    logic [N-1:0]                sync2;     // Pin synchroniser, stage two
    logic [N-1:0]                prev;      // For edge detection
    logic [GROUPS-1:0]           inh;       // Group inhibits
    logic [GROUPS-1:0][GW-1:0]   order;     // Group at each rank
    logic                        req_valid; // Request to processor
    logic [IW-1:0]               req_level; // Level requested
    logic [31:0]                 rdata;     // Read data
  } state_t;

  // Reset value: all disarmed, disabled, identity group order
  function automatic state_t init_state();
    init_state = '0;
    for (int p = 0; p < GROUPS; p++) begin
      init_state.order[p] = GW'(p);
    end
  endfunction : init_state

  localparam state_t RST_STATE = init_state();

  // Lowest set index wins; unrolls into one parallel priority tree
  function automatic logic [IW-1:0] first_set(input logic [N-1:0] v);
    first_set = '0;
    for (int k = N - 1; k >= 0; k--) begin
      if (v[k]) begin
        first_set = IW'(k);
      end
    end
  endfunction : first_set

  // Order word must be a permutation with power-fail group on top
  function automatic logic is_perm(input logic [GROUPS-1:0][GW-1:0] o);
    logic [GROUPS-1:0] seen;
    seen = '0;
    for (int p = 0; p < GROUPS; p++) begin
      seen[o[p]] = 1'b1;
    end
    is_perm = (&seen) && (o[0] == GW'(PF_GROUP));
  endfunction : is_perm

  // Chain members ranked above level lv, worked out rank by rank
  // apart from the priority tree so the checks do not echo it
  function automatic logic higher_busy(input logic [N-1:0]              b,
                                       input logic [GROUPS-1:0][GW-1:0] o,
                                       input logic [IW-1:0]             lv);
    logic reached;
    higher_busy = 1'b0;
    reached     = 1'b0;
    for (int p = 0; p < GROUPS; p++) begin
      for (int i = 0; i < LEVELS; i++) begin
        if (IW'(o[p] * LEVELS + i) == lv) begin
          reached = 1'b1;
        end else if (!reached && b[o[p] * LEVELS + i]) begin
          higher_busy = 1'b1;
        end
      end
    end
  endfunction : higher_busy

  // Byte address of a group's state word
  function automatic logic [APB_AW-1:0] lvl_addr(input int g);
    lvl_addr = APB_AW'(LEVEL_BASE + APB_AW'(g) * LVL_STRIDE);
  endfunction : lvl_addr

  state_t            q;          // Registered state
  state_t            d;          // Next state
  logic [N-1:0]      sig_edge;   // Rising edge of synced pin
  logic [N-1:0]      waiting_v;  // Level waiting
  logic [N-1:0]      active_v;   // Level active
  logic [N-1:0]      dis_v;      // Level disarmed
  logic [N-1:0]      arm_v;      // Level armed
  logic [N-1:0]      inh_v;      // Level under group inhibit
  logic [N-1:0]      elig;       // Enabled, uninhibited, waiting
  logic [N-1:0]      blk;        // Members of the priority chain
  logic [N-1:0]      ordv;       // Chain in rank order
  logic [N-1:0]      trig;       // Software triggers
  logic [N-1:0]      adv_v;      // Waiting to active this cycle
  logic [IW-1:0]     pos;        // Rank position of winner
  logic [IW-1:0]     cand;       // Winning level
  logic              cand_valid; // Winner is eligible waiting
  logic              take;       // Acknowledge accepted
  logic              wr;         // APB write access phase
  logic              st_wr;      // Restore write to a state word
  logic              mapped;     // Address decodes
  logic [31:0]       rd;         // Read mux
  cmd_op_t           op;         // Decoded command
  logic [IW-1:0]     idx;        // Command level index

  // Next-state logic for the whole block
  always_comb begin
    d = q;
    // Two-flop synchronisers; only stage two feeds edge logic
    d.sync1  = level_signal;
    d.sync2  = q.sync1;
    d.prev   = q.sync2;
    sig_edge = q.sync2 & ~q.prev;

    for (int l = 0; l < N; l++) begin
      waiting_v[l] = (q.st[l] == WAITING);
      active_v[l]  = (q.st[l] == ACTIVE);
      dis_v[l]     = (q.st[l] == DISARMED);
      arm_v[l]     = (q.st[l] == ARMED);
      inh_v[l]     = q.inh[l / LEVELS] & INHIBIT_MASK[l / LEVELS];
    end
    elig = waiting_v & q.en & ~inh_v;
    blk  = active_v | elig;
    // chain laid out by group rank
    for (int p = 0; p < GROUPS; p++) begin
      ordv[p*LEVELS +: LEVELS] = blk[q.order[p]*LEVELS +: LEVELS];
    end
    pos        = first_set(ordv);
    cand       = {q.order[pos[IW-1:LW]], pos[LW-1:0]};
    // higher level ahead of active ones
    cand_valid = (|ordv) && elig[cand];

    // APB decode
    wr     = psel && penable && pwrite;
    op     = cmd_op_t'(pwdata[CMD_OP_LSB +: 3]);
    idx    = pwdata[CMD_IDX_LSB +: IW];
    trig   = '0;
    st_wr  = 1'b0;
    mapped = (paddr == INHIBIT_OFS) || (paddr == ORDER_OFS) ||
             (paddr == STATUS_OFS) || (paddr == CMD_OFS);
    rd     = '0;
    if (paddr == INHIBIT_OFS) begin
      rd[GROUPS-1:0] = q.inh;
    end else if (paddr == ORDER_OFS) begin
      rd[GROUPS*GW-1:0] = q.order;
    end else if (paddr == STATUS_OFS) begin
      rd[STAT_REQ_BIT] = q.req_valid;
      rd[STAT_ACT_BIT] = |active_v;
      rd[IW-1:0]       = q.req_level;
    end

    // Control registers
    if (wr && paddr == INHIBIT_OFS) begin
      d.inh = pwdata[GROUPS-1:0];
    end
    // power-fail group pinned to top rank
    if (wr && paddr == ORDER_OFS && is_perm(pwdata[GROUPS*GW-1:0])) begin
      d.order = pwdata[GROUPS*GW-1:0];
    end

    // Command register
    if (wr && paddr == CMD_OFS) begin
      case (op)
        OP_ARM:     d.st[idx] = ARMED;
        // service end by arm or disarm
        OP_DISARM:  d.st[idx] = DISARMED;
        OP_ENABLE:  d.en[idx] = 1'b1;
        OP_DISABLE: d.en[idx] = 1'b0;
        OP_TRIGGER: trig[idx] = 1'b1;
        OP_GRP_EN:  d.en[idx[IW-1:LW]*LEVELS +: LEVELS] = '1;
        OP_GRP_DIS: d.en[idx[IW-1:LW]*LEVELS +: LEVELS] = '0;
        default:    d.st[idx] = q.st[idx];
      endcase
    end

    // Per-group save and restore words
    for (int g = 0; g < GROUPS; g++) begin
      if (paddr == lvl_addr(g)) begin
        mapped = 1'b1;
        for (int i = 0; i < LEVELS; i++) begin
          rd[ST_BITS*i +: ST_BITS] = q.st[g*LEVELS + i];
        end
        if (wr) begin
          st_wr = 1'b1;
          for (int i = 0; i < LEVELS; i++) begin
            d.st[g*LEVELS + i] = lvl_state_t'(pwdata[ST_BITS*i +: ST_BITS]);
          end
        end
      end
      if (paddr == APB_AW'(lvl_addr(g) + ENABLE_OFS)) begin
        mapped = 1'b1;
        rd[LEVELS-1:0] = q.en[g*LEVELS +: LEVELS];
        if (wr) begin
          d.en[g*LEVELS +: LEVELS] = pwdata[LEVELS-1:0];
        end
      end
    end

    // Signals applied after writes so a signal arriving with an arm write is not lost
    for (int l = 0; l < N; l++) begin
      if (d.st[l] == ARMED && (sig_edge[l] || trig[l])) begin
        d.st[l] = WAITING;
      end
    end

    // advance only on acknowledge of presented level
    take = cpu_ack && q.req_valid && cand_valid && (cand == q.req_level);
    if (take) begin
      d.st[cand] = ACTIVE;
    end
    d.req_valid = cand_valid && !take;
    d.req_level = cand;

    // Read data captured in the setup phase
    if (psel && !penable) begin
      d.rdata = mapped ? rd : '0;
    end

    for (int l = 0; l < N; l++) begin
      adv_v[l] = (q.st[l] == WAITING) && (d.st[l] == ACTIVE);
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  // Zero-wait slave: answer in the first access cycle
  assign pready     = penable;
  assign pslverr    = psel && penable && !mapped;
  assign prdata     = q.rdata;
  assign req_valid  = q.req_valid;
  assign req_level  = q.req_level;
  assign active_any = |active_v;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ack_gate_a: assert property (
    (|adv_v) && !st_wr |-> cpu_ack && q.req_valid && adv_v == (N'(1) << q.req_level))
    else $error("level went active without acknowledge");

  inhibit_gate_a: assert property (
    (|adv_v) && !st_wr |-> !inh_v[q.req_level] && q.en[q.req_level])
    else $error("inhibited or disabled level went active");

  higher_block_a: assert property (
    (|adv_v) && !st_wr |-> !higher_busy(blk, q.order, q.req_level))
    else $error("level advanced past a higher blocker");

  req_follow_a: assert property (
    cand_valid && !take |=> q.req_valid && q.req_level == $past(cand))
    else $error("request did not follow the priority network");

  disarm_ignore_a: assert property (
    !wr |=> (($past(dis_v) & ~dis_v) == '0))
    else $error("disarmed level latched a signal");

  armed_latch_a: assert property (
    !wr |=> (($past(arm_v & sig_edge) & ~waiting_v) == '0))
    else $error("armed level dropped a signal");

  pf_top_a: assert property (
    (|elig[PF_LEVELS-1:0]) && !active_v[0] && !take |=> q.req_valid && q.req_level < IW'(PF_LEVELS))
    else $error("power-fail level not on top");

  enable_cmd_a: assert property (
    wr && paddr == CMD_OFS && op == OP_ENABLE |=> q.en[$past(idx)])
    else $error("enable command had no effect");

  grp_dis_a: assert property (
    wr && paddr == CMD_OFS && op == OP_GRP_DIS |=>
      q.en[$past(idx[IW-1:LW])*LEVELS +: LEVELS] == '0)
    else $error("group disable left a level enabled");

  restore_a: assert property (
    wr && paddr == lvl_addr(0) && !cpu_ack && sig_edge == '0 |=>
      q.st[LEVELS-1:0] == $past(pwdata[ST_BITS*LEVELS-1:0]))
    else $error("restore write did not load level states");

  order_a: assert property (
    wr && paddr == ORDER_OFS && is_perm(pwdata[GROUPS*GW-1:0]) |=>
      q.order == $past(pwdata[GROUPS*GW-1:0]))
    else $error("group order not updated");

  nest_c: cover property ((|active_v) ##[1:50] (|adv_v) && !st_wr);
  trig_c: cover property (wr && paddr == CMD_OFS && op == OP_TRIGGER ##1 (|waiting_v));
  ack_c:  cover property (q.req_valid ##[0:5] take);

endmodule : priority_interrupt_system

// >>> dv/cpu_model.sv
/*
  Behavioural processor that watches the interrupt request output and
  acknowledges the presented level, promptly or after a delay.
  Assumes req_valid/req_level registered on pclk and an ack taken at
  the edge where req_valid is still high.
*/
`timescale 1ns/1ps
module cpu_model
  import pis_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       req_valid,
  input  wire logic [5:0] req_level,
  input  wire logic       ack_en,
  input  wire logic [2:0] ack_delay,
  output logic            cpu_ack,
  output logic [7:0]      ack_count,
  output logic [5:0]      ack_level
);
  // Whole model state in one record
  typedef struct packed {
    logic       ack;   // Acknowledge pulse
    logic [2:0] wait_n; // Cycles spent stalling
    logic [1:0] hold;  // Quiet time after an ack
    logic [7:0] cnt;   // Acks given
    logic [5:0] lvl;   // Level last acknowledged
  } cpu_st_t;
  cpu_st_t st_q, st_d;

  // watch request, ack once
  // Holdoff covers the cycle where req_valid still lags the new state
  always_comb begin
    st_d     = st_q;
    st_d.ack = 1'b0;
    if (st_q.hold != 2'h0) begin
      st_d.hold = st_q.hold - 2'h1;
    end else if (ack_en && req_valid) begin
      if (st_q.wait_n >= ack_delay) begin
        st_d.ack    = 1'b1;
        st_d.lvl    = req_level;
        st_d.cnt    = st_q.cnt + 8'h01;
        st_d.wait_n = 3'h0;
        st_d.hold   = 2'h3;
      end else begin
        st_d.wait_n = st_q.wait_n + 3'h1;
      end
    end else begin
      st_d.wait_n = 3'h0;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign cpu_ack   = st_q.ack;
  assign ack_count = st_q.cnt;
  assign ack_level = st_q.lvl;
endmodule : cpu_model

// >>> dv/test_priority_interrupt_system.sv
/*
  Self-checking bench for the priority interrupt system: APB master,
  pin pulses, processor model, random save/restore data.
  Assumes the default shape of 4 groups of 16 levels.
*/
`timescale 1ns/1ps
module test_priority_interrupt_system;
  import pis_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r, rnd = 32'h0001_5F73;
  logic        pready, pslverr, req_valid, cpu_ack, active_any, err_q;
  logic [63:0] level_signal = 64'h0;
  logic [5:0]  req_level, ack_level;
  logic [7:0]  ack_count, c;
  logic        ack_en = 0;
  logic [2:0]  ack_delay = 3'h0;
  int          n_mismatch = 0, total_checks = 0;

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  priority_interrupt_system dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .level_signal(level_signal), .req_valid(req_valid), .req_level(req_level),
    .cpu_ack(cpu_ack), .active_any(active_any));
  cpu_model cpu (.pclk(pclk), .presetn(presetn), .req_valid(req_valid), .req_level(req_level),
    .ack_en(ack_en), .ack_delay(ack_delay), .cpu_ack(cpu_ack), .ack_count(ack_count),
    .ack_level(ack_level));

  task automatic stop_test;
    if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One APB transfer; the caller stands just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      stop_test();
    end
    q = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    check($sformatf("reg %h", a), q & m, e & m);
  endtask : rdchk

  function automatic logic [11:0] st_addr(input int l);
    return LEVEL_BASE + 12'(l / 16) * LVL_STRIDE;
  endfunction : st_addr

  function automatic logic [31:0] stat(input logic v, input logic a, input logic [5:0] l);
    return {v, a, 24'h0, l};
  endfunction : stat

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return (x >> 1) ^ (x[0] ? 32'h8020_0003 : 32'h0);
  endfunction : lfsr

  task automatic cmd(input cmd_op_t op, input logic [5:0] l);
    wr(CMD_OFS, {21'h0, op, 2'h0, l});
  endtask : cmd

  task automatic st_chk(input int l, input lvl_state_t e);
    logic [31:0] q;
    apb(1'b0, st_addr(l), 32'h0, q);
    check("level state", 32'(q[2*(l%16) +: 2]), 32'(e));
  endtask : st_chk

  // Pin high long enough to pass the synchroniser, then low again
  task automatic pin(input int l);
    level_signal[l] <= 1'b1;
    repeat (5) @(posedge pclk);
    level_signal[l] <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : pin

  task automatic wait_ack(input logic [7:0] c0);
    int n;
    n = 0;
    while (ack_count === c0 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 60) begin
      n_mismatch++;
      stop_test();
    end
    repeat (2) @(posedge pclk);
  endtask : wait_ack

  // Guard against a hang anywhere
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(INHIBIT_OFS, 32'h0);
    rdchk(ORDER_OFS, 32'h0000_00E4);
    rdchk(STATUS_OFS, 32'h0);
    for (int g = 0; g < 4; g++) rdchk(st_addr(16 * g), 32'h0);
    apb(1'b0, 12'h010, 32'h0, r);
    check("unmapped error", 32'(err_q), 32'h1);
    pin(20);
    st_chk(20, DISARMED);
    cmd(OP_ARM, 6'h14);
    pin(20);
    st_chk(20, WAITING);
    rdchk(STATUS_OFS, 32'h0);
    cmd(OP_ENABLE, 6'h14);
    rdchk(STATUS_OFS, stat(1, 0, 6'h14));
    cmd(OP_ARM, 6'h11);
    cmd(OP_TRIGGER, 6'h11);
    st_chk(17, WAITING);
    rdchk(STATUS_OFS, stat(1, 0, 6'h14));
    rnd = lfsr(rnd);
    c = ack_count;
    ack_delay <= rnd[2:0];
    ack_en <= 1'b1;
    wait_ack(c);
    check("ack level", 32'(ack_level), 32'h14);
    st_chk(20, ACTIVE);
    check("active any", 32'(active_any), 32'h1);
    cmd(OP_ARM, 6'h05);
    cmd(OP_ENABLE, 6'h05);
    c = ack_count;
    cmd(OP_TRIGGER, 6'h05);
    wait_ack(c);
    check("nested ack level", 32'(ack_level), 32'h05);
    st_chk(5, ACTIVE);
    ack_en <= 1'b0;
    cmd(OP_ARM, 6'h1E);
    cmd(OP_ENABLE, 6'h1E);
    cmd(OP_TRIGGER, 6'h1E);
    rdchk(STATUS_OFS, stat(0, 1, 0), 32'hC000_0000);
    cmd(OP_DISARM, 6'h05);
    rdchk(STATUS_OFS, stat(0, 1, 0), 32'hC000_0000);
    cmd(OP_ARM, 6'h14);
    rdchk(STATUS_OFS, stat(1, 0, 6'h1E));
    wr(INHIBIT_OFS, 32'h2);
    rdchk(STATUS_OFS, 32'h0, 32'hC000_0000);
    wr(INHIBIT_OFS, 32'h0);
    cmd(OP_ARM, 6'h28);
    cmd(OP_ENABLE, 6'h28);
    cmd(OP_TRIGGER, 6'h28);
    rdchk(STATUS_OFS, stat(1, 0, 6'h1E));
    wr(ORDER_OFS, 32'h0000_00D8);
    rdchk(STATUS_OFS, stat(1, 0, 6'h28));
    wr(ORDER_OFS, 32'h0000_00E1);
    rdchk(ORDER_OFS, 32'h0000_00D8);
    cmd(OP_GRP_DIS, 6'h20);
    rdchk(st_addr(32) + ENABLE_OFS, 32'h0);
    rdchk(STATUS_OFS, stat(1, 0, 6'h1E));
    cmd(OP_GRP_EN, 6'h2F);
    rdchk(st_addr(32) + ENABLE_OFS, 32'h0000_FFFF);
    cmd(OP_ARM, 6'h01);
    cmd(OP_ENABLE, 6'h01);
    cmd(OP_TRIGGER, 6'h01);
    wr(INHIBIT_OFS, 32'h0000_000F);
    rdchk(STATUS_OFS, stat(1, 0, 6'h01));
    wr(INHIBIT_OFS, 32'h0);
    cmd(OP_TRIGGER, 6'h32);
    st_chk(50, DISARMED);
    // Random save/restore images, top and bottom groups in turn; last, as they scramble the chain
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      wr(st_addr((i % 2) * 48), rnd);
      rdchk(st_addr((i % 2) * 48), rnd);
      wr(st_addr((i % 2) * 48) + ENABLE_OFS, rnd);
      rdchk(st_addr((i % 2) * 48) + ENABLE_OFS, rnd & 32'h0000_FFFF);
    end
    stop_test();
  end
endmodule : test_priority_interrupt_system
